// [tb.sv]
// tb: self-checking bench for the transceiver reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       core_clk = 1'b0;
	logic       rst      = 1'b1;
	logic [5:0] pll_select = 6'h00;
	logic [2:0] tx_cal_busy = 3'h0, tx_manual = 3'h0, rx_cal_busy = 3'h0, rx_manual = 3'h0;
	logic [2:0] pll_kill = 3'h0, cdr_kill = 3'h0;
	logic [2:0] pll_locked, cdr_data_lock, pll_powerdown, tx_analogreset, tx_digitalreset;
	logic [2:0] tx_ready, rx_analogreset, rx_digitalreset, rx_ready;
	int         mismatches = 0;
	int         samples_checked = 0;
	always #10 core_clk = ~core_clk;
	trsq_top i_trsq_top (.CORE_CLK(core_clk), .RST(rst), .PLL_LOCKED(pll_locked),
		.PLL_SELECT(pll_select), .TX_CAL_BUSY(tx_cal_busy), .TX_MANUAL(tx_manual),
		.RX_CAL_BUSY(rx_cal_busy), .RX_MANUAL(rx_manual), .CDR_DATA_LOCK(cdr_data_lock),
		.PLL_POWERDOWN(pll_powerdown), .TX_ANALOGRESET(tx_analogreset),
		.TX_DIGITALRESET(tx_digitalreset), .TX_READY(tx_ready), .RX_ANALOGRESET(rx_analogreset),
		.RX_DIGITALRESET(rx_digitalreset), .RX_READY(rx_ready));
	trsq_phy_model i_trsq_phy_model (.clk(core_clk), .pll_pd(pll_powerdown), .rx_ana(rx_analogreset),
		.pll_kill(pll_kill), .cdr_kill(cdr_kill), .pll_lock(pll_locked), .cdr_lock(cdr_data_lock));
	task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// checks land on the falling edge, well clear of register updates
	task automatic look(input int n);
		cyc(n);
		@(negedge core_clk);
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		cyc(3000);
		mismatches++;
		results();
	end
	initial begin
		look(9);
		chk("pll_powerdown", pll_powerdown, 3'h7);
		chk("tx_analogreset", tx_analogreset, 3'h7);
		chk("rx_analogreset", rx_analogreset, 3'h7);
		chk("tx_ready", tx_ready, 3'h0);
		chk("rx_ready", rx_ready, 3'h0);
		cyc(1);
		rst <= 1'b0;
		pll_select <= 6'h06; // ch0 on pll2, ch1 on pll1, ch2 on pll0
		look(100);
		chk("pll_powerdown", pll_powerdown, 3'h0);
		chk("tx_analogreset", tx_analogreset, 3'h0);
		chk("tx_ready", tx_ready, 3'h7);
		chk("rx_ready", rx_ready, 3'h7);
		for (int k = 0; k < 3; k++) begin
			cyc(1);
			pll_kill <= 3'(1 << k);
			look(10);
			chk("tx_digitalreset", tx_digitalreset, 3'(4 >> k));
			chk("tx_ready", tx_ready, ~3'(4 >> k));
			cyc(1);
			pll_kill <= 3'h0;
			look(50);
			chk("tx_ready", tx_ready, 3'h7);
		end
		cyc(1);
		tx_manual <= 3'h7;
		cyc(6);
		pll_kill <= 3'h2;
		look(10);
		chk("tx_digitalreset", tx_digitalreset, 3'h0);
		chk("tx_ready", tx_ready, 3'h7);
		cyc(1);
		pll_kill <= 3'h0;
		cdr_kill <= 3'h2;
		look(10);
		chk("rx_digitalreset", rx_digitalreset, 3'h2);
		chk("rx_ready", rx_ready, 3'h5);
		cyc(1);
		cdr_kill <= 3'h0;
		tx_manual <= 3'h0;
		look(70);
		chk("rx_ready", rx_ready, 3'h7);
		cyc(1);
		rx_manual <= 3'h7;
		cyc(6);
		cdr_kill <= 3'h1;
		look(10);
		chk("rx_digitalreset", rx_digitalreset, 3'h0);
		chk("rx_ready", rx_ready, 3'h6);
		cyc(1);
		cdr_kill <= 3'h0;
		cyc(20);
		rx_manual <= 3'h0;
		rx_cal_busy <= 3'h4;
		tx_cal_busy <= 3'h1;
		look(10);
		chk("rx_analogreset", rx_analogreset, 3'h4);
		chk("rx_digitalreset", rx_digitalreset, 3'h4);
		chk("tx_digitalreset", tx_digitalreset, 3'h1);
		cyc(1);
		rx_cal_busy <= 3'h0;
		tx_cal_busy <= 3'h0;
		look(80);
		chk("rx_ready", rx_ready, 3'h7);
		chk("tx_ready", tx_ready, 3'h7);
		cyc(1);
		rst <= 1'b1;
		look(2);
		chk("tx_digitalreset", tx_digitalreset, 3'h7);
		chk("rx_digitalreset", rx_digitalreset, 3'h7);
		chk("pll_powerdown", pll_powerdown, 3'h7);
		cyc(1);
		rst <= 1'b0;
		look(100);
		chk("tx_ready", tx_ready, 3'h7);
		chk("rx_ready", rx_ready, 3'h7);
		results();
	end
endmodule
bind trsq_top trsq_top_chk #(.TX_RELEASE(TX_RELEASE), .RX_RELEASE(RX_RELEASE)) i_trsq_top_chk (
	.CORE_CLK(CORE_CLK), .RST(RST), .RX_CAL_BUSY(RX_CAL_BUSY), .PLL_POWERDOWN(PLL_POWERDOWN),
	.TX_ANALOGRESET(TX_ANALOGRESET), .TX_DIGITALRESET(TX_DIGITALRESET), .TX_READY(TX_READY),
	.RX_ANALOGRESET(RX_ANALOGRESET), .RX_DIGITALRESET(RX_DIGITALRESET), .RX_READY(RX_READY));
`default_nettype wire

// [trsq_chan_if.sv]
// trsq_chan_if: hold request and result of one channel's release sequence
`timescale 1ns/100ps
`default_nettype none
interface trsq_chan_if;
	logic hold;
	logic reset_out;
	logic ready_out;
	modport seq (input hold, output reset_out, output ready_out);
	modport ctl (output hold, input reset_out, input ready_out);
endinterface
`default_nettype wire

// [trsq_phy_model.sv]
// trsq_phy_model: synthesizers and recovery lanes that lock some cycles after release
`timescale 1ns/100ps
`default_nettype none
module trsq_phy_model #(
	parameter int LOCK_DLY = 6
) (
	input  wire logic       clk,
	input  wire logic [2:0] pll_pd,
	input  wire logic [2:0] rx_ana,
	input  wire logic [2:0] pll_kill,
	input  wire logic [2:0] cdr_kill,
	output var  logic [2:0] pll_lock,
	output var  logic [2:0] cdr_lock
);
	int pll_cnt[3];
	int cdr_cnt[3];
	// lock is lost at once while held in reset, regained only after a settling time
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			pll_cnt[i] <= (pll_pd[i] || pll_kill[i]) ? 0 : pll_cnt[i] + 1;
			cdr_cnt[i] <= (rx_ana[i] || cdr_kill[i]) ? 0 : cdr_cnt[i] + 1;
		end
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pll_lock[i] = pll_cnt[i] >= LOCK_DLY;
			cdr_lock[i] = cdr_cnt[i] >= LOCK_DLY;
		end
	end
endmodule
`default_nettype wire

// [trsq_pkg.sv]
// trsq_pkg: shared constants for the transceiver reset sequencer
package trsq_pkg;
	localparam int TRSQ_TX_CHANNELS   = 3;
	localparam int TRSQ_RX_CHANNELS   = 3;
	localparam int TRSQ_PLLS          = 3;
	localparam int TRSQ_SEL_WIDTH     = 2;
	localparam int TRSQ_CNT_WIDTH     = 16;
	localparam int TRSQ_READY_WIDTH   = 4;
	// release delays in nanoseconds, converted to cycles at the core clock
	localparam int TRSQ_CLK_PERIOD_NS = 20;
	localparam int TRSQ_TX_RELEASE_NS = 400;
	localparam int TRSQ_RX_RELEASE_NS = 800;
	localparam int TRSQ_TX_RELEASE_CYC = (TRSQ_TX_RELEASE_NS + TRSQ_CLK_PERIOD_NS - 1)
		/ TRSQ_CLK_PERIOD_NS;
	localparam int TRSQ_RX_RELEASE_CYC = (TRSQ_RX_RELEASE_NS + TRSQ_CLK_PERIOD_NS - 1)
		/ TRSQ_CLK_PERIOD_NS;
	localparam int TRSQ_READY_DELAY_CYC = 4;
	localparam int TRSQ_RST_HOLD_CYC    = 2;

	typedef enum logic [1:0] {
		TRSQ_HOLD    = 2'b00,
		TRSQ_COUNT   = 2'b01,
		TRSQ_SETTLE  = 2'b10,
		TRSQ_DONE    = 2'b11
	} trsq_state_e;
endpackage

// [trsq_release.sv]
// trsq_release: per-channel countdown release and ready delay
`timescale 1ns/100ps
`default_nettype none
module trsq_release
	import trsq_pkg::*;
#(
	parameter int RELEASE_CYC = TRSQ_TX_RELEASE_CYC,
	parameter int READY_CYC   = TRSQ_READY_DELAY_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	trsq_chan_if.seq  ch
);
	initial begin
		if (RELEASE_CYC < 1 || RELEASE_CYC >= (1 << TRSQ_CNT_WIDTH) ||
		    READY_CYC < 1 || READY_CYC >= (1 << TRSQ_READY_WIDTH)) begin
			$error("trsq_release: delay out of range");
		end
	end

	localparam logic [TRSQ_CNT_WIDTH-1:0]   LOAD_CNT = TRSQ_CNT_WIDTH'(RELEASE_CYC - 1);
	localparam logic [TRSQ_READY_WIDTH-1:0] LOAD_RDY = TRSQ_READY_WIDTH'(READY_CYC - 1);

	trsq_state_e                 state_q, state_d;
	logic [TRSQ_CNT_WIDTH-1:0]   cnt_q, cnt_d;
	logic [TRSQ_READY_WIDTH-1:0] rdy_q, rdy_d;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		rdy_d   = rdy_q;
		case (state_q)
			TRSQ_HOLD: begin
				cnt_d = LOAD_CNT;
				if (!ch.hold) begin
					state_d = TRSQ_COUNT;
				end
			end
			TRSQ_COUNT: begin
				if (ch.hold) begin
					state_d = TRSQ_HOLD;
				end else if (cnt_q == '0) begin
					state_d = TRSQ_SETTLE;
					rdy_d   = LOAD_RDY;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			TRSQ_SETTLE: begin
				if (ch.hold) begin
					state_d = TRSQ_HOLD;
				end else if (rdy_q == '0) begin
					state_d = TRSQ_DONE;
				end else begin
					rdy_d = rdy_q - 1'b1;
				end
			end
			TRSQ_DONE: begin
				if (ch.hold) begin
					state_d = TRSQ_HOLD;
				end
			end
			default: state_d = TRSQ_HOLD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= TRSQ_HOLD;
			cnt_q   <= '0;
			rdy_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			rdy_q   <= rdy_d;
		end
	end

	// reset rises combinationally with a new hold so no cycle is missed
	assign ch.reset_out = ch.hold || state_q == TRSQ_HOLD || state_q == TRSQ_COUNT;
	assign ch.ready_out = !ch.hold && state_q == TRSQ_DONE;
endmodule
`default_nettype wire

// [trsq_sync.sv]
// trsq_sync: three-stage synchroniser, output changes when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module trsq_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
	logic [WIDTH-1:0] out_d;

	always_comb begin
		out_d = out_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= din;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule
`default_nettype wire

// [trsq_top.sv]
// trsq_top: reset sequencer for multi-channel serial transceivers
`timescale 1ns/100ps
`default_nettype none
module trsq_top
	import trsq_pkg::*;
#(
	parameter int TX_CH       = trsq_pkg::TRSQ_TX_CHANNELS,
	parameter int RX_CH       = trsq_pkg::TRSQ_RX_CHANNELS,
	parameter int PLLS        = trsq_pkg::TRSQ_PLLS,
	parameter int SEL_W       = trsq_pkg::TRSQ_SEL_WIDTH,
	parameter bit TX_PER_CH   = 1'b1,
	parameter int TX_RELEASE  = trsq_pkg::TRSQ_TX_RELEASE_CYC,
	parameter int RX_RELEASE  = trsq_pkg::TRSQ_RX_RELEASE_CYC,
	parameter int READY_DELAY = trsq_pkg::TRSQ_READY_DELAY_CYC
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST,
	input  wire logic [PLLS-1:0]       PLL_LOCKED,
	input  wire logic [TX_CH*SEL_W-1:0] PLL_SELECT,
	input  wire logic [TX_CH-1:0]      TX_CAL_BUSY,
	input  wire logic [TX_CH-1:0]      TX_MANUAL,
	input  wire logic [RX_CH-1:0]      RX_CAL_BUSY,
	input  wire logic [RX_CH-1:0]      RX_MANUAL,
	input  wire logic [RX_CH-1:0]      CDR_DATA_LOCK,
	output var  logic [PLLS-1:0]       PLL_POWERDOWN,
	output var  logic [TX_CH-1:0]      TX_ANALOGRESET,
	output var  logic [TX_CH-1:0]      TX_DIGITALRESET,
	output var  logic [TX_CH-1:0]      TX_READY,
	output var  logic [RX_CH-1:0]      RX_ANALOGRESET,
	output var  logic [RX_CH-1:0]      RX_DIGITALRESET,
	output var  logic [RX_CH-1:0]      RX_READY
);
	import trsq_pkg::*;

	initial begin
		if (TX_CH < 1 || RX_CH < 1 || PLLS < 1 || SEL_W < 1 || (1 << SEL_W) < PLLS) begin
			$error("trsq_top: channel, synthesizer or index width out of range");
		end
	end

	localparam int NSEQ = TX_PER_CH ? TX_CH : 1;

	// lock-source field for channel c; shared mode always reads field 0
	function automatic logic [SEL_W-1:0] sel_field(input logic [TX_CH*SEL_W-1:0] sel,
	                                               input int c);
		sel_field = sel[(TX_PER_CH ? c : 0)*SEL_W +: SEL_W];
	endfunction

	logic [PLLS-1:0]  lock_s;
	logic [TX_CH-1:0] tx_cal_s, tx_man_s;
	logic [RX_CH-1:0] rx_cal_s, rx_man_s, cdr_s;

	trsq_sync #(.WIDTH(PLLS))  u_sync_lock (.clk(CORE_CLK), .rst(RST), .din(PLL_LOCKED),
	                                        .dout(lock_s));
	trsq_sync #(.WIDTH(TX_CH)) u_sync_txc  (.clk(CORE_CLK), .rst(RST), .din(TX_CAL_BUSY),
	                                        .dout(tx_cal_s));
	trsq_sync #(.WIDTH(TX_CH)) u_sync_txm  (.clk(CORE_CLK), .rst(RST), .din(TX_MANUAL),
	                                        .dout(tx_man_s));
	trsq_sync #(.WIDTH(RX_CH)) u_sync_rxc  (.clk(CORE_CLK), .rst(RST), .din(RX_CAL_BUSY),
	                                        .dout(rx_cal_s));
	trsq_sync #(.WIDTH(RX_CH)) u_sync_rxm  (.clk(CORE_CLK), .rst(RST), .din(RX_MANUAL),
	                                        .dout(rx_man_s));
	trsq_sync #(.WIDTH(RX_CH)) u_sync_cdr  (.clk(CORE_CLK), .rst(RST), .din(CDR_DATA_LOCK),
	                                        .dout(cdr_s));

	// power-down: held through reset, one cycle of release after RST drops
	logic [PLLS-1:0] pd_q, pd_d;
	always_comb begin
		pd_d = '0;
		if (RST) begin
			pd_d = '1;
		end
	end

	// synthesizer power-down resets the locks seen from then on
	logic [TX_CH-1:0] chan_lock;
	logic [TX_CH-1:0] chan_pd;
	logic [TX_CH-1:0] seen_lock_q, seen_lock_d;
	logic [TX_CH-1:0] prev_lock_q, prev_lock_d;

	always_comb begin
		for (int c = 0; c < TX_CH; c++) begin
			logic [SEL_W-1:0] idx;
			idx = sel_field(PLL_SELECT, c);
			// out-of-range index reads as unlocked
			chan_lock[c] = (int'(idx) < PLLS) ? lock_s[idx] : 1'b0;
			chan_pd[c]   = (int'(idx) < PLLS) ? pd_q[idx] : 1'b1;
		end
	end

	always_comb begin
		seen_lock_d = seen_lock_q;
		prev_lock_d = chan_lock;
		for (int c = 0; c < TX_CH; c++) begin
			// cal busy must not clear it: a synthesizer that stays locked gives no new edge
			if (RST || chan_pd[c]) begin
				seen_lock_d[c] = 1'b0;
			end else if (chan_lock[c] && !prev_lock_q[c]) begin
				seen_lock_d[c] = 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pd_q        <= '1;
			seen_lock_q <= '0;
			prev_lock_q <= '1;
		end else begin
			pd_q        <= pd_d;
			seen_lock_q <= seen_lock_d;
			prev_lock_q <= prev_lock_d;
		end
	end

	assign PLL_POWERDOWN = pd_q;

	// transmit sequences
	logic [TX_CH-1:0] tx_hold, tx_rst_int, tx_rdy_int;
	always_comb begin
		for (int c = 0; c < TX_CH; c++) begin
			tx_hold[c] = RST || chan_pd[c] || tx_cal_s[c] || !seen_lock_q[c] ||
			             (!chan_lock[c] && !tx_man_s[c]);
		end
	end

	generate
		for (genvar s = 0; s < NSEQ; s++) begin : g_tx
			trsq_chan_if tif ();
			// shared mode: the one sequence waits on every channel's conditions
			assign tif.hold = TX_PER_CH ? tx_hold[s] : |tx_hold;
			trsq_release #(.RELEASE_CYC(TX_RELEASE), .READY_CYC(READY_DELAY)) u_rel (
				.clk (CORE_CLK),
				.rst (RST),
				.ch  (tif.seq)
			);
			assign tx_rst_int[s] = tif.reset_out;
			assign tx_rdy_int[s] = tif.ready_out;
		end
		for (genvar c = NSEQ; c < TX_CH; c++) begin : g_txfan
			assign tx_rst_int[c] = tx_rst_int[0];
			assign tx_rdy_int[c] = tx_rdy_int[0];
		end
	endgenerate

	always_comb begin
		for (int c = 0; c < TX_CH; c++) begin
			TX_ANALOGRESET[c] = RST || chan_pd[c];
		end
	end
	assign TX_DIGITALRESET = tx_rst_int;
	assign TX_READY        = tx_rdy_int & ~tx_rst_int;

	// receive sequences, always one per channel
	logic [RX_CH-1:0] rx_hold, rx_rst_int, rx_rdy_int;
	always_comb begin
		for (int c = 0; c < RX_CH; c++) begin
			RX_ANALOGRESET[c] = RST || rx_cal_s[c];
			// manual mode: data lock never resets, but ready still waits for it
			rx_hold[c] = RX_ANALOGRESET[c] || rx_cal_s[c] ||
			             (!cdr_s[c] && !rx_man_s[c]);
		end
	end

	generate
		for (genvar c = 0; c < RX_CH; c++) begin : g_rx
			trsq_chan_if rif ();
			assign rif.hold = rx_hold[c];
			trsq_release #(.RELEASE_CYC(RX_RELEASE), .READY_CYC(READY_DELAY)) u_rel (
				.clk (CORE_CLK),
				.rst (RST),
				.ch  (rif.seq)
			);
			assign rx_rst_int[c] = rif.reset_out;
			assign rx_rdy_int[c] = rif.ready_out && cdr_s[c];
		end
	endgenerate

	assign RX_DIGITALRESET = rx_rst_int;
	assign RX_READY        = rx_rdy_int & ~rx_rst_int;
endmodule
`default_nettype wire

// [trsq_top_chk.sv]
// trsq_top_chk: pin-level assertions for the transceiver reset sequencer
`timescale 1ns/100ps
`default_nettype none
module trsq_top_chk
	import trsq_pkg::*;
#(
	parameter int TX_RELEASE = TRSQ_TX_RELEASE_CYC,
	parameter int RX_RELEASE = TRSQ_RX_RELEASE_CYC
) (
	input wire logic                        CORE_CLK,
	input wire logic                        RST,
	input wire logic [TRSQ_RX_CHANNELS-1:0] RX_CAL_BUSY,
	input wire logic [TRSQ_PLLS-1:0]        PLL_POWERDOWN,
	input wire logic [TRSQ_TX_CHANNELS-1:0] TX_ANALOGRESET,
	input wire logic [TRSQ_TX_CHANNELS-1:0] TX_DIGITALRESET,
	input wire logic [TRSQ_TX_CHANNELS-1:0] TX_READY,
	input wire logic [TRSQ_RX_CHANNELS-1:0] RX_ANALOGRESET,
	input wire logic [TRSQ_RX_CHANNELS-1:0] RX_DIGITALRESET,
	input wire logic [TRSQ_RX_CHANNELS-1:0] RX_READY
);
	// cycles since lane 0 analog reset was last high; sync delay only adds to it
	int tx_q;
	int rx_q;
	always_ff @(posedge CORE_CLK) begin
		tx_q <= TX_ANALOGRESET[0] ? 0 : tx_q + 1;
		rx_q <= RX_ANALOGRESET[0] ? 0 : rx_q + 1;
	end
	default clocking @(posedge CORE_CLK); endclocking
	// reset-time checks carry no disable, they watch reset itself
	a_tx_ana_rst: assert property (RST |-> TX_ANALOGRESET == '1)
		else $error("tx analog reset low in reset");
	a_rx_ana_rst: assert property (RST |-> RX_ANALOGRESET == '1)
		else $error("rx analog reset low in reset");
	a_rst_hold_all: assert property (RST ##1 RST |-> PLL_POWERDOWN == '1
		&& TX_DIGITALRESET == '1 && RX_DIGITALRESET == '1) else $error("reset output low in reset");
	a_pd_sync_rel: assert property (disable iff (RST) !RST |=> PLL_POWERDOWN == '0)
		else $error("power-down not released");
	a_tx_pd_dig: assert property (disable iff (RST) (TX_ANALOGRESET & ~TX_DIGITALRESET) == '0)
		else $error("tx digital released under analog reset");
	a_rx_ana_dig: assert property (disable iff (RST) (RX_ANALOGRESET & ~RX_DIGITALRESET) == '0)
		else $error("rx digital released under analog reset");
	a_ready_in_rst: assert property (disable iff (RST) ((TX_DIGITALRESET & TX_READY) |
		(RX_DIGITALRESET & RX_READY)) == '0) else $error("ready high in digital reset");
	a_tx_count_len: assert property (disable iff (RST) $fell(TX_DIGITALRESET[0]) |-> tx_q >= TX_RELEASE)
		else $error("tx digital released early");
	a_rx_count_len: assert property (disable iff (RST) $fell(RX_DIGITALRESET[0]) |-> rx_q >= RX_RELEASE)
		else $error("rx digital released early");
	a_tx_ready_dly: assert property (disable iff (RST) $fell(TX_DIGITALRESET[0]) |-> !TX_READY[0] [*2]
		##[1:6] (TX_READY[0] || TX_DIGITALRESET[0])) else $error("tx ready delay wrong");
	a_rx_ready_dly: assert property (disable iff (RST) $fell(RX_DIGITALRESET[0]) |-> !RX_READY[0] [*2]
		##[1:6] (RX_READY[0] || RX_DIGITALRESET[0])) else $error("rx ready delay wrong");
	a_rx_cal_ana: assert property (disable iff (RST) RX_CAL_BUSY[2] [*5] |-> RX_ANALOGRESET[2])
		else $error("rx analog reset ignores cal busy");
	cover property ($rose(TX_READY[1]));
	cover property ($rose(RX_READY[2]));
	cover property ($fell(RX_DIGITALRESET[0]));
endmodule
`default_nettype wire
